// ### test/opt_load.sv
// Purpose : model of the user load on the two optical outputs
// Assumes : a high level energizes the load
// Notes   : load state lags the output by one clock
`timescale 1ns/100ps
module opt_load (
   input  wire logic       clk_i,
   input  wire logic [1:0] opt_i,
   output      logic [1:0] on_o
);
   // load energized while its output is driven high
   always_ff @(posedge clk_i)
   begin
      on_o <= opt_i;
   end
endmodule

// ### test/tb.sv
// Purpose : self-checking bench for flow_alarm_totalizer
// Assumes : tick of 20 cycles and confirm window of 40 cycles
// Notes   : registers reached through wishbone tasks
`timescale 1ns/100ps
module tb;
   localparam int TK = 20;
   logic               clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic [7:0]         adr   = 8'h00;
   logic [31:0]        wdat  = 32'h0;
   logic [31:0]        nvin  = 32'h123;
   logic               we    = 1'b0;
   logic               stb   = 1'b0;
   logic               enter = 1'b0;
   logic               nvl   = 1'b0;
   logic [9:0]         flow  = 10'h0;
   logic signed [10:0] temp  = 11'h0;
   logic [31:0]        rdat, rd, nvd;
   logic [1:0]         opt, load;
   logic               ack, nvw, m_hi, m_lo, m_t, evt;
   int                 fail_count = 0;
   int                 samples_checked = 0;
   always #4 clk_i = ~clk_i;
   flow_alarm_totalizer #(.TICK_CYC(TK), .CONFIRM_CYC(40)) DUT (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF),
      .wb_cyc_i(stb), .wb_stb_i(stb), .wb_ack_o(ack), .flow_i(flow), .temp_i(temp),
      .enter_i(enter), .nv_load_i(nvl), .nv_data_i(nvin), .nv_wr_o(nvw), .nv_data_o(nvd),
      .opt_o(opt), .flow_over_limit_marker_o(m_hi), .flow_under_limit_marker_o(m_lo),
      .temperature_alarm_marker_o(m_t), .tot_event_o(evt));
   opt_load LOAD (.clk_i(clk_i), .opt_i(opt), .on_o(load));
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a;
      wdat <= d;
      we <= w;
      stb <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      rd = rdat;
      if (n >= 50)
         fail_count++;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic pulse_enter;
      enter <= 1'b1;
      @(posedge clk_i);
      enter <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog against a hung handshake or wait
   initial
   begin
      #100000;
      fail_count++;
      wrap_up();
   end
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      wt(3);
      rst_i <= 1'b0;
      wb(0, 8'h00, 0); chk("ctrl", rd, 0);
      wb(0, 8'h04, 0); chk("flow lim", rd, 32'h03E8_0000);
      wb(0, 8'h30, 0); chk("unmapped", rd, 0);
      wb(1, 8'h04, 32'h0FFF_0064);
      wb(0, 8'h04, 0);
      chk("flow clamp", rd, 32'h03E8_0064);
      wb(1, 8'h08, 32'h03FF_0400);
      wb(0, 8'h08, 0);
      chk("temp clamp", rd, 32'h03E7_FF9D);
      wb(1, 8'h24, 32'h11);
      wb(1, 8'h04, 32'h0384_0064);                            // high above low
      wb(1, 8'h0C, 32'h2);
      wb(1, 8'h00, 32'h1);
      flow <= 10'h3B6;
      wt(10); chk("hi early", m_hi, 0);
      wt(2 * TK + 2); chk("hi", m_hi, 1);
      wt(2); chk("load hi", load, 2'b10);
      flow <= 10'h1F4;
      wt(2); chk("hi drop", m_hi, 0);
      flow <= 10'h064;
      wt(2 * TK + 3); chk("lo", m_lo, 1);
      wt(2); chk("load lo", load, 2'b01);
      wb(1, 8'h00, 32'h3);
      flow <= 10'h1F4;
      wt(3); chk("lo held", m_lo, 1);
      wb(1, 8'h04, 32'h0384_0064);
      wt(2); chk("lo cleared", m_lo, 0);
      wb(1, 8'h08, 32'h01F4_07CE);
      wb(1, 8'h24, 32'h1C);
      wb(1, 8'h00, 32'h4);
      temp <= 11'h7CE;
      wt(3); chk("temp", m_t, 1);
      wt(1); chk("load temp", load, 2'b01);
      temp <= 11'h000;
      wt(2); chk("temp drop", m_t, 0);
      wb(1, 8'h10, 32'h64);
      flow <= 10'h032;
      wb(1, 8'h00, 32'h10);
      wt(3 * TK); wb(0, 8'h1C, 0); chk("below start", rd, 0);
      flow <= 10'h0C8;
      wt(3 * TK + 2);
      flow <= 10'h000;
      wt(2); wb(0, 8'h1C, 0); chk("total", rd == 600 || rd == 800, 1);
      wt(TK + 2); chk("nv save", nvd, rd);
      wb(1, 8'h14, rd); chk("event", evt, 1);
      wt(2);
      chk("load evt", load, 2'b10);
      wb(1, 8'h00, 32'h30);
      wt(50); pulse_enter(); wt(2);
      wb(0, 8'h1C, 0); chk("lapsed", rd == 600 || rd == 800, 1);
      wb(1, 8'h00, 32'h30);
      wt(5); pulse_enter(); wt(2);
      wb(0, 8'h1C, 0); chk("cleared", rd, 0);
      wb(1, 8'h14, 0); chk("no event", evt, 0);
      nvl <= 1'b1;
      wt(1);
      nvl <= 1'b0;
      wb(0, 8'h1C, 0); chk("reload", rd, 32'h123);
      wb(1, 8'h18, 32'h64);
      flow <= 10'h0C8;
      wt(TK + 2);
      wb(0, 8'h1C, 0);
      chk("stopped", rd, 32'h123);
      wrap_up();
   end
endmodule

// ### verilog/flow_alarm_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : shared constants and types for the flow/temperature alarm and
//           main totalizer block
// Assumes : 125 MHz system clock, 32-bit classic Wishbone register bus
// Notes   : flow in tenths of a percent of full scale, temperature in
//           signed tenths of a degree C
//////////////////////////////////////////////////////////////////////////////
package flow_alarm_pkg;

   // ***********************************************************************
   // timing
   // ***********************************************************************
   localparam int unsigned CLK_FREQ_HZ    = 125_000_000;
   localparam int unsigned TICK_PERIOD_S  = 1;
   localparam int unsigned TICK_CYC_DEF   = CLK_FREQ_HZ * TICK_PERIOD_S;
   localparam int unsigned CONFIRM_WIN_S  = 2;
   localparam int unsigned CONFIRM_CYC_DEF = CLK_FREQ_HZ * CONFIRM_WIN_S;

   // ***********************************************************************
   // value ranges
   // ***********************************************************************
   localparam int          FLOW_W      = 10;
   localparam int          TEMP_W      = 11;
   localparam int          DLY_W       = 12;
   localparam int          TOT_W       = 32;
   localparam logic [9:0]  FLOW_MAX    = 10'h3E8;   // 100.0 %F.S.
   localparam logic [11:0] DLY_MAX     = 12'hE10;   // 3600 s
   localparam logic signed [10:0] TEMP_MIN = -11'sd99;  // -9.9 C
   localparam logic signed [10:0] TEMP_MAX = 11'sd999;  // 99.9 C

   // ***********************************************************************
   // register byte offsets
   // ***********************************************************************
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_FLOW_LIM  = 8'h04;
   localparam logic [7:0] REG_TEMP_LIM  = 8'h08;
   localparam logic [7:0] REG_DELAY     = 8'h0C;
   localparam logic [7:0] REG_TOT_START = 8'h10;
   localparam logic [7:0] REG_EVENT_VOL = 8'h14;
   localparam logic [7:0] REG_STOP_VOL  = 8'h18;
   localparam logic [7:0] REG_TOTAL     = 8'h1C;
   localparam logic [7:0] REG_STATUS    = 8'h20;
   localparam logic [7:0] REG_OUT_SEL   = 8'h24;

   // field positions: low half at bit 0, high half at bit 16
   localparam int LO_POS = 0;
   localparam int HI_POS = 16;
   localparam int CONFIRM_REQ_BIT = 5;           // write-only request bit

   // reset values
   localparam logic [9:0]  FLOW_LO_RST = 10'h000;
   localparam logic [9:0]  FLOW_HI_RST = 10'h3E8;
   localparam logic [31:0] VOL_RST     = 32'h0000_0000;

   // ***********************************************************************
   // types
   // ***********************************************************************
   typedef struct packed {
      logic tot_en;
      logic temp_latch;
      logic temp_en;
      logic flow_latch;
      logic flow_en;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '0;

   typedef enum logic [2:0] {
      OPT_OFF     = 3'h0,
      OPT_FLOW_LO = 3'h1,
      OPT_FLOW_HI = 3'h2,
      OPT_TOT_EVT = 3'h3,
      OPT_TEMP_LO = 3'h4,
      OPT_TEMP_HI = 3'h5
   } opt_sel_t;

   typedef enum logic [0:0] {
      CONF_IDLE  = 1'b0,
      CONF_ARMED = 1'b1
   } confirm_state_t;

endpackage

// ### verilog/flow_alarm_totalizer.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose : flow and temperature limit alarms with action delay and latch,
//           two optical outputs, and a main totalizer with non-volatile save
// Assumes : flow, temperature and enter key come from logic on clk_i
// Notes   : registers on classic Wishbone, one word each
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module flow_alarm_totalizer #(
   parameter int unsigned TICK_CYC    = flow_alarm_pkg::TICK_CYC_DEF,
   parameter int unsigned CONFIRM_CYC = flow_alarm_pkg::CONFIRM_CYC_DEF
) (
   input  wire logic                                     clk_i,
   input  wire logic                                     rst_i,
   input  wire logic [7:0]                               wb_adr_i,
   input  wire logic [31:0]                              wb_dat_i,
   output      logic [31:0]                              wb_dat_o,
   input  wire logic                                     wb_we_i,
   input  wire logic [3:0]                               wb_sel_i,
   input  wire logic                                     wb_cyc_i,
   input  wire logic                                     wb_stb_i,
   output      logic                                     wb_ack_o,
   input  wire logic [flow_alarm_pkg::FLOW_W-1:0]        flow_i,
   input  wire logic signed [flow_alarm_pkg::TEMP_W-1:0] temp_i,
   input  wire logic                                     enter_i,
   input  wire logic                                     nv_load_i,
   input  wire logic [flow_alarm_pkg::TOT_W-1:0]         nv_data_i,
   output      logic                                     nv_wr_o,
   output      logic [flow_alarm_pkg::TOT_W-1:0]         nv_data_o,
   output      logic [1:0]                               opt_o,
   output      logic                                     flow_over_limit_marker_o,
   output      logic                                     flow_under_limit_marker_o,
   output      logic                                     temperature_alarm_marker_o,
   output      logic                                     tot_event_o
);

   if (TICK_CYC < 2 || CONFIRM_CYC < 2)
   begin : g_bad_param
      $error("tick and confirm window must be at least two cycles");
   end

   // ***********************************************************************
   // register bus
   // ***********************************************************************
   flow_alarm_pkg::ctrl_t    ctrl_reg;
   logic [9:0]               flow_lo_reg;
   logic [9:0]               flow_hi_reg;
   logic signed [10:0]       temp_lo_reg;
   logic signed [10:0]       temp_hi_reg;
   logic [11:0]              flow_dly_reg;
   logic [11:0]              temp_dly_reg;
   logic [9:0]               tot_start_reg;
   logic [31:0]              event_vol_reg;
   logic [31:0]              stop_vol_reg;
   logic [31:0]              total_reg;
   logic [5:0]               out_sel_reg;
   logic                     ack_reg;
   logic [31:0]              dat_reg;
   logic                     stopped_reg;
   logic [3:0]               marker;
   flow_alarm_pkg::confirm_state_t conf_reg;

   // request decode; a write lands on the edge where ack is seen
   wire        req       = wb_cyc_i & wb_stb_i;
   wire        ack_next  = req & ~ack_reg;
   wire        wr        = req & ack_reg & wb_we_i & (&wb_sel_i);
   wire        wr_ctrl   = wr & (wb_adr_i == flow_alarm_pkg::REG_CTRL);
   wire        wr_flim   = wr & (wb_adr_i == flow_alarm_pkg::REG_FLOW_LIM);
   wire        wr_tlim   = wr & (wb_adr_i == flow_alarm_pkg::REG_TEMP_LIM);
   wire        wr_dly    = wr & (wb_adr_i == flow_alarm_pkg::REG_DELAY);
   wire        wr_start  = wr & (wb_adr_i == flow_alarm_pkg::REG_TOT_START);
   wire        wr_evt    = wr & (wb_adr_i == flow_alarm_pkg::REG_EVENT_VOL);
   wire        wr_stop   = wr & (wb_adr_i == flow_alarm_pkg::REG_STOP_VOL);
   wire        wr_osel   = wr & (wb_adr_i == flow_alarm_pkg::REG_OUT_SEL);
   wire        conf_req  = wr_ctrl & wb_dat_i[flow_alarm_pkg::CONFIRM_REQ_BIT];

   // incoming fields clamped into their documented ranges
   wire [9:0]  wd_lo     = wb_dat_i[flow_alarm_pkg::LO_POS +: 10];
   wire [9:0]  wd_hi     = wb_dat_i[flow_alarm_pkg::HI_POS +: 10];
   wire [9:0]  lo_clamp  = (wd_lo > flow_alarm_pkg::FLOW_MAX) ? flow_alarm_pkg::FLOW_MAX : wd_lo;
   wire [9:0]  hi_clamp  = (wd_hi > flow_alarm_pkg::FLOW_MAX) ? flow_alarm_pkg::FLOW_MAX : wd_hi;
   wire [11:0] wd_dlo    = wb_dat_i[flow_alarm_pkg::LO_POS +: 12];
   wire [11:0] wd_dhi    = wb_dat_i[flow_alarm_pkg::HI_POS +: 12];
   wire [11:0] dlo_clamp = (wd_dlo > flow_alarm_pkg::DLY_MAX) ? flow_alarm_pkg::DLY_MAX : wd_dlo;
   wire [11:0] dhi_clamp = (wd_dhi > flow_alarm_pkg::DLY_MAX) ? flow_alarm_pkg::DLY_MAX : wd_dhi;
   wire signed [10:0] wd_tlo = wb_dat_i[flow_alarm_pkg::LO_POS +: 11];
   wire signed [10:0] wd_thi = wb_dat_i[flow_alarm_pkg::HI_POS +: 11];
   wire signed [10:0] tlo_clamp = (wd_tlo < flow_alarm_pkg::TEMP_MIN) ? flow_alarm_pkg::TEMP_MIN :
                                  (wd_tlo > flow_alarm_pkg::TEMP_MAX) ? flow_alarm_pkg::TEMP_MAX :
                                  wd_tlo;
   wire signed [10:0] thi_clamp = (wd_thi < flow_alarm_pkg::TEMP_MIN) ? flow_alarm_pkg::TEMP_MIN :
                                  (wd_thi > flow_alarm_pkg::TEMP_MAX) ? flow_alarm_pkg::TEMP_MAX :
                                  wd_thi;

   // read selection; unmapped offsets read zero
   wire [31:0] status_word = {26'h0, conf_reg, stopped_reg, tot_event_o, marker[3:2] != 2'b00,
                              marker[1], marker[0]};
   wire [31:0] rd_mux =
      (wb_adr_i == flow_alarm_pkg::REG_CTRL)      ? {27'h0, ctrl_reg} :
      (wb_adr_i == flow_alarm_pkg::REG_FLOW_LIM)  ? {6'h0, flow_hi_reg, 6'h0, flow_lo_reg} :
      (wb_adr_i == flow_alarm_pkg::REG_TEMP_LIM)  ? {{5{temp_hi_reg[10]}}, temp_hi_reg,
                                                      {5{temp_lo_reg[10]}}, temp_lo_reg} :
      (wb_adr_i == flow_alarm_pkg::REG_DELAY)     ? {4'h0, temp_dly_reg, 4'h0, flow_dly_reg} :
      (wb_adr_i == flow_alarm_pkg::REG_TOT_START) ? {22'h0, tot_start_reg} :
      (wb_adr_i == flow_alarm_pkg::REG_EVENT_VOL) ? event_vol_reg :
      (wb_adr_i == flow_alarm_pkg::REG_STOP_VOL)  ? stop_vol_reg :
      (wb_adr_i == flow_alarm_pkg::REG_TOTAL)     ? total_reg :
      (wb_adr_i == flow_alarm_pkg::REG_STATUS)    ? status_word :
      (wb_adr_i == flow_alarm_pkg::REG_OUT_SEL)   ? {26'h0, out_sel_reg} :
      32'h0000_0000;

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // bus answer: ack one cycle after the request, dropped the next
   always_ff @(posedge clk_i)
   begin
      ack_reg <= rst_i ? 1'b0 : ack_next;
      dat_reg <= rst_i ? 32'h0000_0000 : (ack_next ? rd_mux : dat_reg);
   end

   // configuration registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg      <= flow_alarm_pkg::CTRL_RST;
         flow_lo_reg   <= flow_alarm_pkg::FLOW_LO_RST;
         flow_hi_reg   <= flow_alarm_pkg::FLOW_HI_RST;
         temp_lo_reg   <= 11'sd0;
         temp_hi_reg   <= flow_alarm_pkg::TEMP_MAX;
         flow_dly_reg  <= 12'h000;
         temp_dly_reg  <= 12'h000;
         tot_start_reg <= 10'h000;
         event_vol_reg <= flow_alarm_pkg::VOL_RST;
         stop_vol_reg  <= flow_alarm_pkg::VOL_RST;
         out_sel_reg   <= 6'h00;
      end
      else
      begin
         if (wr_ctrl) ctrl_reg <= flow_alarm_pkg::ctrl_t'(wb_dat_i[4:0]);
         if (wr_flim) flow_lo_reg <= lo_clamp;
         if (wr_flim) flow_hi_reg <= hi_clamp;
         if (wr_tlim) temp_lo_reg <= tlo_clamp;
         if (wr_tlim) temp_hi_reg <= thi_clamp;
         if (wr_dly) flow_dly_reg <= dlo_clamp;
         if (wr_dly) temp_dly_reg <= dhi_clamp;
         if (wr_start) tot_start_reg <= lo_clamp;
         if (wr_evt) event_vol_reg <= wb_dat_i;
         if (wr_stop) stop_vol_reg <= wb_dat_i;
         if (wr_osel) out_sel_reg <= wb_dat_i[5:0];
      end
   end

   // ***********************************************************************
   // one-second tick
   // ***********************************************************************
   logic [31:0] tick_cnt_reg;
   wire         tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

   // free-running divider for delays and saves
   always_ff @(posedge clk_i)
   begin
      tick_cnt_reg <= (rst_i | tick) ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
   end

   // ***********************************************************************
   // alarm channels: 0 flow high, 1 flow low, 2 temp high, 3 temp low
   // ***********************************************************************
   // conditions at or beyond the limit
   wire [3:0] cond = {temp_i <= temp_lo_reg, temp_i >= temp_hi_reg,
                      flow_i <= flow_lo_reg, flow_i >= flow_hi_reg};
   wire [3:0] ch_en    = {{2{ctrl_reg.temp_en}}, {2{ctrl_reg.flow_en}}};
   wire [3:0] ch_latch = {{2{ctrl_reg.temp_latch}}, {2{ctrl_reg.flow_latch}}};
   // reconfiguration drops a held alarm; so does switching latch or enable off
   wire flow_alarm_pkg::ctrl_t wd_ctrl = flow_alarm_pkg::ctrl_t'(wb_dat_i[4:0]);
   wire flow_drop = wr_flim | wr_dly | (wr_ctrl & ~(wd_ctrl.flow_en & wd_ctrl.flow_latch));
   wire temp_drop = wr_tlim | wr_dly | (wr_ctrl & ~(wd_ctrl.temp_en & wd_ctrl.temp_latch));
   wire [3:0] ch_recfg = {{2{temp_drop}}, {2{flow_drop}}};
   logic [3:0] live_reg;
   logic [3:0] held_reg;

   for (genvar i = 0; i < 4; i++)
   begin : g_alarm
      logic [11:0] cnt_reg;
      // each channel has its own delay count
      wire  [11:0] dly     = (i < 2) ? flow_dly_reg : temp_dly_reg;
      wire         armed   = cond[i] & ch_en[i];
      wire         expired = cnt_reg >= dly;

      // count restarts when value returns inside
      always_ff @(posedge clk_i)
      begin
         if (rst_i | ~armed)
            cnt_reg <= 12'h000;
         else if (tick & ~expired)
            cnt_reg <= cnt_reg + 12'h001;
      end

      always_ff @(posedge clk_i)
      begin
         live_reg[i] <= ~rst_i & armed & expired;
         held_reg[i] <= ~rst_i & ch_en[i] & ch_latch[i] & ~ch_recfg[i]
                        & (held_reg[i] | live_reg[i]);
      end

      assign marker[i] = live_reg[i] | held_reg[i];
   end

   assign flow_over_limit_marker_o   = marker[0];
   assign flow_under_limit_marker_o  = marker[1];
   assign temperature_alarm_marker_o = marker[2] | marker[3];

   // ***********************************************************************
   // main totalizer
   // ***********************************************************************
   logic [31:0] conf_cnt_reg;
   logic        nv_wr_reg;

   wire tot_run   = ctrl_reg.tot_en & (flow_i >= tot_start_reg) & ~stopped_reg;
   wire confirmed = (conf_reg == flow_alarm_pkg::CONF_ARMED) & enter_i;
   wire lapse     = conf_cnt_reg == 32'(CONFIRM_CYC - 1);
   // stop only with a non-zero stop volume
   wire stop_hit  = (stop_vol_reg != 32'h0000_0000) & (total_reg >= stop_vol_reg);

   // integrate flow each second; reload at power-up
   always_ff @(posedge clk_i)
   begin
      if (rst_i | confirmed)
         total_reg <= 32'h0000_0000;
      else if (nv_load_i)
         total_reg <= nv_data_i;
      else if (tick & tot_run)
         total_reg <= total_reg + {22'h0, flow_i};
   end

   always_ff @(posedge clk_i)
   begin
      stopped_reg <= ~rst_i & ~confirmed & stop_hit;
   end

   // equality event, off for zero volume
   assign tot_event_o = (event_vol_reg != 32'h0000_0000) & (total_reg == event_vol_reg);

   // confirmation window; a fresh request restarts it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         conf_reg <= flow_alarm_pkg::CONF_IDLE;
      else
         unique case (conf_reg)
            flow_alarm_pkg::CONF_IDLE:
               conf_reg <= conf_req ? flow_alarm_pkg::CONF_ARMED : flow_alarm_pkg::CONF_IDLE;
            flow_alarm_pkg::CONF_ARMED:
               conf_reg <= (conf_req | ~(confirmed | lapse)) ? flow_alarm_pkg::CONF_ARMED
                                                             : flow_alarm_pkg::CONF_IDLE;
         endcase
      // lapse clears the count with the state, so it never reaches the window length
      conf_cnt_reg <= (rst_i | conf_req | lapse | conf_reg == flow_alarm_pkg::CONF_IDLE)
                      ? 32'h0000_0000 : conf_cnt_reg + 32'h0000_0001;
   end

   // save the total once per second
   always_ff @(posedge clk_i)
   begin
      nv_wr_reg <= ~rst_i & tick;
      nv_data_o <= rst_i ? 32'h0000_0000 : (tick ? total_reg : nv_data_o);
   end
   assign nv_wr_o = nv_wr_reg;

   // ***********************************************************************
   // optical outputs
   // ***********************************************************************
   for (genvar k = 0; k < 2; k++)
   begin : g_opt
      wire [2:0] sel = out_sel_reg[3*k +: 3];
      always_ff @(posedge clk_i)
      begin
         opt_o[k] <= ~rst_i & (
            (sel == flow_alarm_pkg::OPT_FLOW_HI) ? marker[0] :
            (sel == flow_alarm_pkg::OPT_FLOW_LO) ? marker[1] :
            (sel == flow_alarm_pkg::OPT_TEMP_HI) ? marker[2] :
            (sel == flow_alarm_pkg::OPT_TEMP_LO) ? marker[3] :
            (sel == flow_alarm_pkg::OPT_TOT_EVT) ? tot_event_o : 1'b0);
      end
   end

   // ***********************************************************************
   // assertions
   // ***********************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_flow_delay: assert property (ch_en[0] && !cond[0] ##1 cond[0]
                                  && flow_dly_reg > 12'h000 |=> !live_reg[0])
      else $error("flow high alarm raised before delay");
   a_track_live: assert property (!ctrl_reg.flow_latch && marker[1] |-> $past(cond[1]))
      else $error("unlatched low flow alarm without condition");
   a_latch_hold: assert property (marker[0] && ctrl_reg.flow_latch && ch_en[0]
                                  && !ch_recfg[0] |=> marker[0])
      else $error("latched alarm dropped");
   a_temp_off: assert property ($past(rst_i) |-> !ctrl_reg.temp_en && !marker[2])
      else $error("temperature alarm not off after reset");
   a_count_restart: assert property (!cond[2] |=> g_alarm[2].cnt_reg == 12'h000)
      else $error("delay count kept across return inside");
   a_start_gate: assert property (tick && flow_i < tot_start_reg
                                  && !nv_load_i && !confirmed |=> $stable(total_reg))
      else $error("total moved below start threshold");
   a_event_zero: assert property (event_vol_reg == 32'h0000_0000 |-> !tot_event_o)
      else $error("event with zero event volume");
   a_stop_zero: assert property (stopped_reg |-> $past(stop_vol_reg) != 32'h0000_0000)
      else $error("stopped with zero stop volume");
   a_reset_confirm: assert property (confirmed |=> total_reg == 32'h0000_0000)
      else $error("confirmed reset did not clear total");
   a_reset_lapse: assert property (conf_cnt_reg < 32'(CONFIRM_CYC))
      else $error("confirmation window overran");
   a_nv_save: assert property (tick |=> nv_wr_o && nv_data_o == $past(total_reg))
      else $error("total not saved on tick");

   c_high_alarm: cover property (opt_o[0] && out_sel_reg[2:0] == flow_alarm_pkg::OPT_FLOW_HI);
   c_confirm:    cover property (confirmed);
   c_lapse:      cover property (conf_reg == flow_alarm_pkg::CONF_ARMED && lapse && !enter_i);
   c_event:      cover property (tot_event_o);

endmodule
